// [design/pfh_pkg.sv]
// Package for the parallel FIFO host port: timing counts and mode codes.
// Assumes a single 40 MHz clock shared by both ends.
package pfh_pkg;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int STROBE_MIN_NS   = 50;
  localparam int FLAG_IDLE_NS    = 80;
  localparam int WR_GAP_NS       = 50;
  // Least times round up to whole cycles
  localparam int STROBE_CYC      = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAG_IDLE_CYC   = (FLAG_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_GAP_CYC      = (STROBE_MIN_NS + FLAG_IDLE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int WR_GAP_CYC      = (WR_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 4;
  localparam int DATA_W          = 8;
  // Interface-select code that picks the parallel FIFO mode
  localparam logic [1:0] SEL_FIFO = 2'h1;
  typedef enum logic [1:0] {PFH_IDLE, PFH_STROBE, PFH_GAP} pfh_host_state_t;
endpackage

// [design/pfh_if.sv]
// Interface joining the device end and the host end of the FIFO port.
// The data bus level is resolved here from the two enables.
interface pfh_if;
  logic                         rx_byte_waiting_n;
  logic                         tx_accept_ready_n;
  logic                         rd_strobe_n;
  logic                         wr_strobe;
  logic [pfh_pkg::DATA_W-1:0]   dev_data_out;
  logic                         dev_data_oe;
  logic [pfh_pkg::DATA_W-1:0]   host_data_out;
  logic                         host_data_oe;
  logic [pfh_pkg::DATA_W-1:0]   fifo_data_bus;

  assign fifo_data_bus = dev_data_oe  ? dev_data_out  :
                         host_data_oe ? host_data_out : 8'hff;

  modport device (
    output rx_byte_waiting_n,
    output tx_accept_ready_n,
    input  rd_strobe_n,
    input  wr_strobe,
    output dev_data_out,
    output dev_data_oe,
    input  fifo_data_bus
  );
  modport host (
    input  rx_byte_waiting_n,
    input  tx_accept_ready_n,
    output rd_strobe_n,
    output wr_strobe,
    output host_data_out,
    output host_data_oe,
    input  fifo_data_bus
  );
endinterface

// [design/pfh_device.sv]
// Device end of the parallel FIFO port: flags, read fetch, write capture, mode select.
// Assumes host strobes are synchronous to CLK; the buffers sit on the user side.
module pfh_device (
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RESET,
  // Link
  pfh_if.device                           LINK,
  // Mode straps
  input  wire logic                       BOOTSTRAP_PROGRAM_N,
  input  wire logic                       INTERFACE_SELECT_A,
  input  wire logic                       INTERFACE_SELECT_B,
  output logic                            FIFO_MODE,
  output logic                            BOOTSTRAP_MODE,
  // Receive buffer side
  input  wire logic                       RX_VALID,
  input  wire logic [pfh_pkg::DATA_W-1:0] RX_DATA,
  output logic                            RX_TAKE,
  // Transmit buffer side
  input  wire logic                       TX_SPACE,
  output logic                            TX_VALID,
  output logic [pfh_pkg::DATA_W-1:0]      TX_DATA
);
  logic                        rd_prev_r, rd_prev_nxt;
  logic                        wr_prev_r, wr_prev_nxt;
  logic                        rxf_n_r, rxf_n_nxt;
  logic                        txe_n_r, txe_n_nxt;
  logic [pfh_pkg::CNT_W-1:0]   rx_hold_r, rx_hold_nxt;
  logic [pfh_pkg::CNT_W-1:0]   tx_hold_r, tx_hold_nxt;
  logic [pfh_pkg::DATA_W-1:0]  rx_byte_r, rx_byte_nxt;
  logic                        rx_full_r, rx_full_nxt;
  logic                        oe_r, oe_nxt;
  logic                        take_r, take_nxt;
  logic                        txv_r, txv_nxt;
  logic [pfh_pkg::DATA_W-1:0]  txd_r, txd_nxt;
  logic                        fifo_r, fifo_nxt;
  logic                        boot_r, boot_nxt;
  logic                        rst_seen_r;
  logic                        rd_fall, wr_fall;

  assign rd_fall = rd_prev_r & ~LINK.rd_strobe_n;
  assign wr_fall = wr_prev_r & ~LINK.wr_strobe;

  // Mode is caught on the first edge after reset release
  always_comb begin
    fifo_nxt = fifo_r;
    boot_nxt = boot_r;
    if (!rst_seen_r) begin
      boot_nxt = ~BOOTSTRAP_PROGRAM_N;
      fifo_nxt = BOOTSTRAP_PROGRAM_N &&
                 ({INTERFACE_SELECT_B, INTERFACE_SELECT_A} == pfh_pkg::SEL_FIFO);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      fifo_r     <= 1'b0;
      boot_r     <= 1'b0;
      rst_seen_r <= 1'b0;
    end else begin
      fifo_r     <= fifo_nxt;
      boot_r     <= boot_nxt;
      rst_seen_r <= 1'b1;
    end
  end

  // Idle counters step down to zero and rest there
  function automatic logic [pfh_pkg::CNT_W-1:0] hold_step(
    input logic [pfh_pkg::CNT_W-1:0] cnt
  );
    logic [pfh_pkg::CNT_W-1:0] res;
    res = cnt;
    if (cnt != '0) begin
      res = cnt - 1'b1;
    end
    return res;
  endfunction

  // Strobe history for edge detection; reset matches the idle levels
  always_comb begin
    rd_prev_nxt = LINK.rd_strobe_n;
    wr_prev_nxt = LINK.wr_strobe;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_prev_r <= 1'b1;
      wr_prev_r <= 1'b0;
    end else begin
      rd_prev_r <= rd_prev_nxt;
      wr_prev_r <= wr_prev_nxt;
    end
  end

  // Receive staging: hold the offered byte until the host reads it
  always_comb begin
    rx_byte_nxt = rx_byte_r;
    rx_full_nxt = rx_full_r;
    take_nxt    = 1'b0;
    if (fifo_r) begin
      // Loading waits for a high read strobe so the driven byte stays put
      if (!rx_full_r && RX_VALID && LINK.rd_strobe_n) begin
        rx_byte_nxt = RX_DATA;
        rx_full_nxt = 1'b1;
        take_nxt    = 1'b1;
      end
      if (rd_fall && rx_full_r) begin
        rx_full_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_byte_r <= 8'h00;
      rx_full_r <= 1'b0;
      take_r    <= 1'b0;
    end else begin
      rx_byte_r <= rx_byte_nxt;
      rx_full_r <= rx_full_nxt;
      take_r    <= take_nxt;
    end
  end

  // Receive flag and bus drive; the flag rests high for the idle time after a read
  always_comb begin
    rxf_n_nxt   = 1'b1;
    rx_hold_nxt = hold_step(rx_hold_r);
    oe_nxt      = fifo_r & ~LINK.rd_strobe_n;
    if (fifo_r) begin
      if (!LINK.rd_strobe_n || rd_fall) begin
        rx_hold_nxt = pfh_pkg::CNT_W'(pfh_pkg::FLAG_IDLE_CYC);
      end else begin
        rxf_n_nxt = ~(rx_full_r && rx_hold_r == '0);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rxf_n_r   <= 1'b1;
      rx_hold_r <= '0;
      oe_r      <= 1'b0;
    end else begin
      rxf_n_r   <= rxf_n_nxt;
      rx_hold_r <= rx_hold_nxt;
      oe_r      <= oe_nxt;
    end
  end

  // Transmit capture: the bus byte is taken when the write strobe falls
  always_comb begin
    txv_nxt = 1'b0;
    txd_nxt = txd_r;
    if (fifo_r && wr_fall) begin
      txv_nxt = 1'b1;
      txd_nxt = LINK.fifo_data_bus;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      txv_r <= 1'b0;
      txd_r <= 8'h00;
    end else begin
      txv_r <= txv_nxt;
      txd_r <= txd_nxt;
    end
  end

  // Transmit flag rests high while the strobe is up and for the idle time after it
  always_comb begin
    txe_n_nxt   = 1'b1;
    tx_hold_nxt = hold_step(tx_hold_r);
    if (fifo_r) begin
      if (LINK.wr_strobe || wr_fall) begin
        tx_hold_nxt = pfh_pkg::CNT_W'(pfh_pkg::FLAG_IDLE_CYC);
      end else begin
        txe_n_nxt = ~(TX_SPACE && tx_hold_r == '0);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      txe_n_r   <= 1'b1;
      tx_hold_r <= '0;
    end else begin
      txe_n_r   <= txe_n_nxt;
      tx_hold_r <= tx_hold_nxt;
    end
  end

  assign LINK.rx_byte_waiting_n = rxf_n_r;
  assign LINK.tx_accept_ready_n = txe_n_r;
  assign LINK.dev_data_out      = rx_byte_r;
  assign LINK.dev_data_oe       = oe_r;
  assign FIFO_MODE              = fifo_r;
  assign BOOTSTRAP_MODE         = boot_r;
  assign RX_TAKE                = take_r;
  assign TX_VALID               = txv_r;
  assign TX_DATA                = txd_r;
endmodule

// [design/pfh_host.sv]
// Host end of the parallel FIFO port: issues read and write strobe cycles.
// Assumes the device end shares CLK; user requests are single-cycle pulses.
module pfh_host (
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RESET,
  // Link
  pfh_if.host                             LINK,
  // User requests
  input  wire logic                       RD_REQ,
  input  wire logic                       WR_REQ,
  input  wire logic [pfh_pkg::DATA_W-1:0] WR_DATA,
  output logic                            BUSY,
  output logic                            RD_VALID,
  output logic [pfh_pkg::DATA_W-1:0]      RD_DATA
);
  pfh_pkg::pfh_host_state_t  st_r, st_nxt;
  logic                      is_rd_r, is_rd_nxt;
  logic [pfh_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic                      rdn_r, rdn_nxt;
  logic                      wr_r, wr_nxt;
  logic                      oe_r, oe_nxt;
  logic [pfh_pkg::DATA_W-1:0] wd_r, wd_nxt;
  logic                      rv_r, rv_nxt;
  logic [pfh_pkg::DATA_W-1:0] rd_r, rd_nxt;
  logic                      busy_r, busy_nxt;

  always_comb begin
    st_nxt    = st_r;
    is_rd_nxt = is_rd_r;
    cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    rdn_nxt   = rdn_r;
    wr_nxt    = wr_r;
    oe_nxt    = oe_r;
    wd_nxt    = wd_r;
    rv_nxt    = 1'b0;
    rd_nxt    = rd_r;
    case (st_r)
      pfh_pkg::PFH_IDLE: begin
        if (RD_REQ && !LINK.rx_byte_waiting_n) begin
          st_nxt    = pfh_pkg::PFH_STROBE;
          is_rd_nxt = 1'b1;
          rdn_nxt   = 1'b0;
          cnt_nxt   = pfh_pkg::CNT_W'(pfh_pkg::STROBE_CYC);
        end else if (WR_REQ && !LINK.tx_accept_ready_n) begin
          st_nxt    = pfh_pkg::PFH_STROBE;
          is_rd_nxt = 1'b0;
          wr_nxt    = 1'b1;
          oe_nxt    = 1'b1;
          wd_nxt    = WR_DATA;
          cnt_nxt   = pfh_pkg::CNT_W'(pfh_pkg::STROBE_CYC);
        end
      end
      pfh_pkg::PFH_STROBE: begin
        if (cnt_r <= 4'h1) begin
          st_nxt = pfh_pkg::PFH_GAP;
          if (is_rd_r) begin
            rdn_nxt = 1'b1;
            rv_nxt  = 1'b1;
            rd_nxt  = LINK.fifo_data_bus;
            cnt_nxt = pfh_pkg::CNT_W'(pfh_pkg::RD_GAP_CYC);
          end else begin
            wr_nxt  = 1'b0;
            cnt_nxt = pfh_pkg::CNT_W'(pfh_pkg::WR_GAP_CYC);
          end
        end
      end
      pfh_pkg::PFH_GAP: begin
        oe_nxt = 1'b0;
        if (cnt_r <= 4'h1) begin
          st_nxt = pfh_pkg::PFH_IDLE;
        end
      end
      default: st_nxt = pfh_pkg::PFH_IDLE;
    endcase
    busy_nxt = (st_nxt != pfh_pkg::PFH_IDLE);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r    <= pfh_pkg::PFH_IDLE;
      busy_r  <= 1'b0;
      is_rd_r <= 1'b0;
      cnt_r   <= '0;
      rdn_r   <= 1'b1;
      wr_r    <= 1'b0;
      oe_r    <= 1'b0;
      wd_r    <= 8'h00;
      rv_r    <= 1'b0;
      rd_r    <= 8'h00;
    end else begin
      st_r    <= st_nxt;
      is_rd_r <= is_rd_nxt;
      cnt_r   <= cnt_nxt;
      rdn_r   <= rdn_nxt;
      wr_r    <= wr_nxt;
      oe_r    <= oe_nxt;
      wd_r    <= wd_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      busy_r  <= busy_nxt;
    end
  end

  assign LINK.rd_strobe_n   = rdn_r;
  assign LINK.wr_strobe     = wr_r;
  assign LINK.host_data_oe  = oe_r;
  assign LINK.host_data_out = wd_r;
  assign BUSY               = busy_r;
  assign RD_VALID           = rv_r;
  assign RD_DATA            = rd_r;
endmodule

// [testbench/pfh_chk.sv]
// Checker for the FIFO port link: strobe spacing, flag holds, bus drive.
// Assumes one clock; inputs are the interface signals.
module pfh_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Link
  input wire logic rx_byte_waiting_n,
  input wire logic tx_accept_ready_n,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe,
  input wire logic dev_data_oe,
  input wire logic host_data_oe
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_rd_flag;
    $fell(rd_strobe_n) |=> rx_byte_waiting_n;
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("rx flag low after read");
  property p_rx_hold;
    $rose(rd_strobe_n) |-> rx_byte_waiting_n[*4];
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx flag idle too short");
  property p_tx_hold;
    $fell(wr_strobe) |-> tx_accept_ready_n[*4];
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx flag idle too short");
  property p_oe_on;
    $fell(rd_strobe_n) |=> dev_data_oe throughout (!rd_strobe_n)[*1];
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven in read");
  property p_oe_off;
    rd_strobe_n && $past(rd_strobe_n) |-> !dev_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven while idle");
  property p_rd_ok;
    $fell(rd_strobe_n) |-> !$past(rx_byte_waiting_n);
  endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("read without byte");
  property p_wr_ok;
    $rose(wr_strobe) |-> !$past(tx_accept_ready_n);
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("write while not ready");
  property p_rd_w;
    $fell(rd_strobe_n) |-> (!rd_strobe_n)[*2];
  endproperty
  a_rd_w: assert property (p_rd_w) else $error("read strobe too short");
  property p_rd_gap;
    $rose(rd_strobe_n) |-> rd_strobe_n[*6];
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read gap too short");
  property p_wr_w;
    $rose(wr_strobe) |-> wr_strobe[*2] ##1 (!wr_strobe)[*2];
  endproperty
  a_wr_w: assert property (p_wr_w) else $error("write strobe or gap short");
  property p_no_clash;
    !(dev_data_oe && host_data_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive bus");
endmodule

// [testbench/parallel_fifo_host_port_tb.sv]
// Testbench joining host and device ends of the FIFO port.
// Assumes a 40 MHz clock; both user sides are driven here.
module parallel_fifo_host_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       CLK = 0, RESET = 1, bootstrap_program_n_n = 1, sel_a = 1, sel_b = 0;
  logic       rx_valid = 0, tx_space = 1, rd_req = 0, wr_req = 0;
  logic [7:0] rx_data = 8'h00, wr_data = 8'h00, d;
  logic       fifo_mode, boot_mode, rx_take, tx_valid, busy, rd_valid;
  logic [7:0] tx_data, rd_data;
  logic [7:0] rxq[$], rdq[$], txq[$];
  int         bad_count = 0, samples_checked = 0, cyc = 0, i, k;
  pfh_if bus ();
  pfh_device pfh_device_i (.CLK(CLK), .RESET(RESET), .LINK(bus), .BOOTSTRAP_PROGRAM_N(bootstrap_program_n_n),
    .INTERFACE_SELECT_A(sel_a), .INTERFACE_SELECT_B(sel_b), .FIFO_MODE(fifo_mode),
    .BOOTSTRAP_MODE(boot_mode), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_TAKE(rx_take),
    .TX_SPACE(tx_space), .TX_VALID(tx_valid), .TX_DATA(tx_data));
  pfh_host pfh_host_i (.CLK(CLK), .RESET(RESET), .LINK(bus), .RD_REQ(rd_req), .WR_REQ(wr_req),
    .WR_DATA(wr_data), .BUSY(busy), .RD_VALID(rd_valid), .RD_DATA(rd_data));
  pfh_chk pfh_chk_i (.CLK(CLK), .RESET(RESET), .rx_byte_waiting_n(bus.rx_byte_waiting_n),
    .tx_accept_ready_n(bus.tx_accept_ready_n), .rd_strobe_n(bus.rd_strobe_n),
    .wr_strobe(bus.wr_strobe), .dev_data_oe(bus.dev_data_oe), .host_data_oe(bus.host_data_oe));
  always #12.5 CLK = ~CLK;
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge CLK);
    #2;
  endtask
  task do_reset;
    RESET = 1;
    tick(16);
    RESET = 0;
    tick(6);
  endtask
  task do_rd;
    for (i = 0; i < 400 && (busy !== 0 || bus.rx_byte_waiting_n !== 0); i++) tick(1);
    rd_req = 1;
    tick(1);
    rd_req = 0;
    chk_bit(busy, 1);
    for (i = 0; i < 50 && rd_valid !== 1; i++) tick(1);
    chk_byte(rd_data, rdq.pop_front());
  endtask
  task do_wr(input logic [7:0] v);
    for (i = 0; i < 400 && (busy !== 0 || bus.tx_accept_ready_n !== 0); i++) tick(1);
    wr_data = v;
    wr_req = 1;
    txq.push_back(v);
    tick(1);
    wr_req = 0;
  endtask
  // Receive feeder, transmit sink and run limit
  always @(posedge CLK) begin
    #2;
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      wrap_up();
    end
    if (rx_take === 1) void'(rxq.pop_front());
    rx_valid = rxq.size() > 0;
    rx_data = rx_valid ? rxq[0] : 8'h00;
    if (tx_valid === 1) chk_byte(tx_data, txq.pop_front());
  end
  initial begin
    i = $urandom(34925);
    for (k = 0; k < 6; k++) begin
      {bootstrap_program_n_n, sel_b, sel_a} = (k < 4) ? {1'b1, k[1:0]} : {k[0], 2'h1};
      do_reset();
      chk_bit(fifo_mode, k == 1 || k == 5);
      chk_bit(boot_mode, k == 4);
      chk_bit(bus.tx_accept_ready_n, !(k == 1 || k == 5));
    end
    chk_bit(bus.rx_byte_waiting_n, 1);
    tx_space = 0;
    tick(8);
    chk_bit(bus.tx_accept_ready_n, 1);
    for (k = 0; k < 40; k++) begin
      d = (k < 4) ? {8{k[0]}} : 8'($urandom);
      if (k % 2 == 0 || $urandom % 2) begin
        tx_space = 1'($urandom);
        rxq.push_back(d);
        rdq.push_back(d);
        do_rd();
      end else begin
        tx_space = 1;
        do_wr(d);
      end
    end
    tx_space = 1;
    tick(20);
    chk_bit(bus.rx_byte_waiting_n, 1);
    chk_byte(8'(txq.size()), 8'h00);
    wrap_up();
  end
endmodule
